// ---- logic/dcac_dac_alarm.sv ----
// DAC holding and latch registers, load modes, clearing, and the monitor alarm path.
// Assumes a serial engine issuing one-cycle register requests and ADC logic on ref_clk.
`timescale 1ns/1ns

// Summary of operation
// - Each DAC has holding data feeding an output latch; output follows the latch.
// - Host read of a DAC channel returns its latch, not its holding data.
// - Sync-mode channels update their latch only on an internal load trigger or on leaving clear.
// - Writing 1 to the load trigger bit loads all sync-mode channels read since the previous trigger at once.
// - Async-mode channels copy written holding data into the latch right after the write.
// - A load trigger reloads only channels read by the host since the previous trigger.
// - While a clear pin is low, channels selected by its clear-select register stay cleared.
// - Writing the software clear register clears the channels it selects.
// - Alarm events chosen by the source register clear the auto-clear enabled channels.
// - Entering clear loads the clear code to the output, holding data unchanged.
// - Leaving clear reloads the output from holding data, whatever the load mode.
// - Overtemp flag sets when die temperature exceeds 150 degrees C.
// - Out-of-range input sets its status bit; global flag is OR of status bits.
// - Latched mode: bit stays until condition ends and status read; persisting ones re-set.
// - Unlatched mode: each status bit clears as soon as its condition ends.
// - Open-drain fault pin drives low while any unmasked status bit is 1, else released.
// - Analog input alarms when result is above high or below low threshold.
// - High threshold below low threshold keeps that input's alarm permanently set.
// - Each temperature sensor has separate high-limit and low-limit alarm bits.
// - Only unmasked events drive the fault pin; masked ones still set status.
// - Latched status bits also clear on hardware, software or power-on reset.
// - Alarm sets only after N consecutive out-of-range conversions, N programmable.
// - Alarm clears only once the result is back inside by the hysteresis amount.
module dcac_dac_alarm
  import dcac_pkg::*;
#(
  parameter int TEMP_LSB_PER_C = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register request from the serial engine
  input wire dcac_req_t reg_req,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // Monitor results from the conversion logic
  input wire dcac_mon_t mon_in,
  input wire logic die_temp_valid,
  input wire logic [RES_W-1:0] die_temp,
  // Hardware clear pins
  input wire logic hw_clear_pin_a_n,
  input wire logic hw_clear_pin_b_n,
  // DAC codes to the resistor strings
  output dcac_dac_arr_t dac_code,
  // Open-drain fault pin
  output logic global_fault_pin_n_o,
  output logic global_fault_pin_n_oe_n
);

  // ----------------------------------------------------------------
  // Elaboration checks and derived limits
  // ----------------------------------------------------------------
  localparam int OT_CODE_I = OVERTEMP_C * TEMP_LSB_PER_C;
  localparam int OT_CLR_I = (OVERTEMP_C - OVERTEMP_HYST_C) * TEMP_LSB_PER_C;
  localparam logic [RES_W-1:0] OT_CODE = OT_CODE_I[RES_W-1:0];
  localparam logic [RES_W-1:0] OT_CLR = OT_CLR_I[RES_W-1:0];
  generate
    if (TEMP_LSB_PER_C < 1 || OT_CODE_I >= (1 << RES_W)) begin : g_bad_scale
      $error("TEMP_LSB_PER_C puts the die limit outside the result range");
    end
  endgenerate
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dcac_dac_arr_t hold_r, hold_nxt, latch_r, latch_nxt, code_r, code_nxt, out_r, out_nxt;
  logic [NUM_DAC-1:0] sync_sel_r, sync_sel_nxt, sw_clr_r, sw_clr_nxt;
  logic [NUM_DAC-1:0] sel_a_r, sel_a_nxt, sel_b_r, sel_b_nxt;
  logic [NUM_DAC-1:0] auto_en_r, auto_en_nxt, read_seen_r, read_seen_nxt;
  logic [NUM_DAC-1:0] cleared_r, cleared_nxt;
  logic [STAT_W-1:0] auto_src_r, auto_src_nxt, status_r, status_nxt;
  logic [STAT_W-1:0] unmask_r, unmask_nxt;
  logic hold_dis_r, hold_dis_nxt, ot_r, ot_nxt, pin_oe_n_r, pin_oe_n_nxt;
  logic [15:0] deb_r, deb_nxt;
  logic [NUM_MON-1:0][RES_W-1:0] hi_r, hi_nxt, lo_r, lo_nxt;
  logic [NUM_MON-1:0][HYST_W-1:0] hyst_r, hyst_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [2:0] pin_a_s, pin_b_s;
  logic pin_a_low_r, pin_b_low_r;
  logic [NUM_MON-1:0] mon_hi, mon_lo;
  logic [NUM_MON-1:0][HYST_W-1:0] mon_hyst;
  logic [NUM_MON-1:0][CNT_W-1:0] mon_need;
  logic [STAT_W-1:0] cond;
  logic [NUM_DAC-1:0] clr_now;
  logic load_evt, sw_rst, stat_rd, dac_hit, code_hit;
  logic [3:0] dac_idx, code_idx;
  logic [7:0] dac_off, code_off;
  // ----------------------------------------------------------------
  // Clear pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_a_s <= 3'h7;
      pin_b_s <= 3'h7;
      pin_a_low_r <= 1'b0;
      pin_b_low_r <= 1'b0;
    end else begin
      pin_a_s <= {pin_a_s[1:0], hw_clear_pin_a_n};
      pin_b_s <= {pin_b_s[1:0], hw_clear_pin_b_n};
      if (pin_a_s[2] == pin_a_s[1]) pin_a_low_r <= ~pin_a_s[2];
      if (pin_b_s[2] == pin_b_s[1]) pin_b_low_r <= ~pin_b_s[2];
    end
  end
  // ----------------------------------------------------------------
  // Limit detectors
  // ----------------------------------------------------------------
  generate
    for (genvar m = 0; m < NUM_MON; m++) begin : g_mon
      if (m < NUM_IN) begin : g_in
        assign mon_hyst[m] = hyst_r[m];
        assign mon_need[m] = dcac_need_in(deb_r[DEB_IN_LSB +: 3]);
        assign cond[m] = mon_hi[m] | mon_lo[m] | (hi_r[m] < lo_r[m]);
      end else begin : g_temp
        assign mon_hyst[m] = {2'b00, hyst_r[m][TEMP_HYST_W-1:0]};
        assign mon_need[m] = dcac_need_temp(deb_r[DEB_TEMP_LSB +: 2]);
        assign cond[STAT_UPPER_LSB + m - NUM_IN] = mon_hi[m];
        assign cond[STAT_LOWER_LSB + m - NUM_IN] = mon_lo[m];
      end
      dcac_limit_det u_det (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sample_valid(mon_in.valid[m]),
        .sample(mon_in.result[m]),
        .limit_hi(hi_r[m]),
        .limit_lo(lo_r[m]),
        .hyst(mon_hyst[m]),
        .need_count(mon_need[m]),
        .hi_alarm(mon_hi[m]),
        .lo_alarm(mon_lo[m])
      );
    end
  endgenerate
  assign cond[STAT_OVERTEMP_BIT] = ot_r;
  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    hold_nxt = hold_r;
    latch_nxt = latch_r;
    code_nxt = code_r;
    sync_sel_nxt = sync_sel_r;
    sw_clr_nxt = sw_clr_r;
    sel_a_nxt = sel_a_r;
    sel_b_nxt = sel_b_r;
    auto_en_nxt = auto_en_r;
    auto_src_nxt = auto_src_r;
    unmask_nxt = unmask_r;
    hold_dis_nxt = hold_dis_r;
    deb_nxt = deb_r;
    hi_nxt = hi_r;
    lo_nxt = lo_r;
    hyst_nxt = hyst_r;
    read_seen_nxt = read_seen_r;
    ot_nxt = ot_r;
    rdata_nxt = '0;
    rvalid_nxt = reg_req.rd;
    dac_off = reg_req.addr - ADDR_DAC_BASE;
    code_off = reg_req.addr - ADDR_CODE_BASE;
    dac_idx = dac_off[3:0];
    code_idx = code_off[3:0];
    dac_hit = (reg_req.addr >= ADDR_DAC_BASE) && (dac_off < 8'(NUM_DAC));
    code_hit = (reg_req.addr >= ADDR_CODE_BASE) && (code_off < 8'(NUM_DAC));
    load_evt = reg_req.wr && (reg_req.addr == ADDR_CFG0) && reg_req.wdata[CFG0_LOAD_BIT];
    sw_rst = reg_req.wr && (reg_req.addr == ADDR_CFG0) && reg_req.wdata[CFG0_SWRST_BIT];
    stat_rd = reg_req.rd && (reg_req.addr == ADDR_STATUS);
    // Overtemp with fixed hysteresis
    if (die_temp_valid) begin
      if (die_temp > OT_CODE) begin
        ot_nxt = 1'b1;
      end else if (die_temp <= OT_CLR) begin
        ot_nxt = 1'b0;
      end
    end
    // Register writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        ADDR_DEBOUNCE: deb_nxt = reg_req.wdata;
        ADDR_ALM_CTRL: begin
          unmask_nxt = reg_req.wdata[STAT_W-1:0];
          hold_dis_nxt = reg_req.wdata[ALM_HOLD_DIS_BIT];
        end
        ADDR_SW_CLR: sw_clr_nxt = reg_req.wdata[NUM_DAC-1:0];
        ADDR_PIN_SEL_A: sel_a_nxt = reg_req.wdata[NUM_DAC-1:0];
        ADDR_PIN_SEL_B: sel_b_nxt = reg_req.wdata[NUM_DAC-1:0];
        ADDR_LOAD_CFG: sync_sel_nxt = reg_req.wdata[NUM_DAC-1:0];
        ADDR_AUTO_SRC: auto_src_nxt = reg_req.wdata[STAT_W-1:0];
        ADDR_AUTO_EN: auto_en_nxt = reg_req.wdata[NUM_DAC-1:0];
        default: ;
      endcase
      for (int m = 0; m < NUM_MON; m++) begin
        if (reg_req.addr == ADDR_HI_BASE + 8'(m)) begin
          hi_nxt[m] = reg_req.wdata[RES_W-1:0];
        end
        if (reg_req.addr == ADDR_LO_BASE + 8'(m)) begin
          lo_nxt[m] = reg_req.wdata[RES_W-1:0];
        end
        if (reg_req.addr == ADDR_HYST_BASE + 8'(m)) begin
          hyst_nxt[m] = reg_req.wdata[HYST_W-1:0];
        end
      end
      if (code_hit) code_nxt[code_idx] = reg_req.wdata[DAC_W-1:0];
      if (dac_hit) begin
        hold_nxt[dac_idx] = reg_req.wdata[DAC_W-1:0];
        if (!sync_sel_r[dac_idx]) begin
          latch_nxt[dac_idx] = reg_req.wdata[DAC_W-1:0];
        end
      end
    end
    // Synchronous load of read channels
    if (load_evt) begin
      for (int i = 0; i < NUM_DAC; i++) begin
        if (sync_sel_r[i] && read_seen_r[i]) begin
          latch_nxt[i] = hold_r[i];
        end
      end
      read_seen_nxt = '0;
    end
    if (reg_req.rd && dac_hit) read_seen_nxt[dac_idx] = 1'b1;
    // Status bits
    if (sw_rst) begin
      status_nxt = '0;
    end else if (hold_dis_r) begin
      status_nxt = cond;
    end else begin
      status_nxt = cond | (status_r & ~{STAT_W{stat_rd}});
    end
    pin_oe_n_nxt = ~|(status_nxt & unmask_r);
    // Clear state and output selection
    clr_now = ({NUM_DAC{pin_a_low_r}} & sel_a_r) | ({NUM_DAC{pin_b_low_r}} & sel_b_r);
    clr_now = clr_now | sw_clr_r;
    clr_now = clr_now | ({NUM_DAC{|(status_r & auto_src_r)}} & auto_en_r);
    cleared_nxt = clr_now;
    for (int i = 0; i < NUM_DAC; i++) begin
      if (cleared_r[i] && !clr_now[i]) begin
        latch_nxt[i] = hold_nxt[i];
      end
      out_nxt[i] = clr_now[i] ? code_r[i] : latch_nxt[i];
    end
    // Register reads
    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_DEBOUNCE: rdata_nxt = deb_r;
        ADDR_CFG0: rdata_nxt[CFG0_GFLAG_BIT] = |status_r;
        ADDR_ALM_CTRL: begin
          rdata_nxt[STAT_W-1:0] = unmask_r;
          rdata_nxt[ALM_HOLD_DIS_BIT] = hold_dis_r;
        end
        ADDR_STATUS: rdata_nxt[STAT_W-1:0] = status_r;
        ADDR_SW_CLR: rdata_nxt[NUM_DAC-1:0] = sw_clr_r;
        ADDR_PIN_SEL_A: rdata_nxt[NUM_DAC-1:0] = sel_a_r;
        ADDR_PIN_SEL_B: rdata_nxt[NUM_DAC-1:0] = sel_b_r;
        ADDR_LOAD_CFG: rdata_nxt[NUM_DAC-1:0] = sync_sel_r;
        ADDR_AUTO_SRC: rdata_nxt[STAT_W-1:0] = auto_src_r;
        ADDR_AUTO_EN: rdata_nxt[NUM_DAC-1:0] = auto_en_r;
        default: ;
      endcase
      for (int m = 0; m < NUM_MON; m++) begin
        if (reg_req.addr == ADDR_HI_BASE + 8'(m)) begin
          rdata_nxt[RES_W-1:0] = hi_r[m];
        end
        if (reg_req.addr == ADDR_LO_BASE + 8'(m)) begin
          rdata_nxt[RES_W-1:0] = lo_r[m];
        end
        if (reg_req.addr == ADDR_HYST_BASE + 8'(m)) begin
          rdata_nxt[HYST_W-1:0] = hyst_r[m];
        end
      end
      if (dac_hit) rdata_nxt[DAC_W-1:0] = latch_r[dac_idx];
      if (code_hit) rdata_nxt[DAC_W-1:0] = code_r[code_idx];
    end
  end
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= '0;
      latch_r <= '0;
      code_r <= '0;
      out_r <= '0;
      sync_sel_r <= '0;
      sw_clr_r <= '0;
      sel_a_r <= '0;
      sel_b_r <= '0;
      auto_en_r <= '0;
      auto_src_r <= '0;
      read_seen_r <= '0;
      cleared_r <= '0;
      status_r <= '0;
      unmask_r <= UNMASK_RST;
      hold_dis_r <= 1'b0;
      ot_r <= 1'b0;
      pin_oe_n_r <= 1'b1;
      deb_r <= DEBOUNCE_RST;
      hi_r <= {NUM_MON{HI_RST}};
      lo_r <= {NUM_MON{LO_RST}};
      hyst_r <= {NUM_MON{HYST_RST}};
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
      latch_r <= latch_nxt;
      code_r <= code_nxt;
      out_r <= out_nxt;
      sync_sel_r <= sync_sel_nxt;
      sw_clr_r <= sw_clr_nxt;
      sel_a_r <= sel_a_nxt;
      sel_b_r <= sel_b_nxt;
      auto_en_r <= auto_en_nxt;
      auto_src_r <= auto_src_nxt;
      read_seen_r <= read_seen_nxt;
      cleared_r <= cleared_nxt;
      status_r <= status_nxt;
      unmask_r <= unmask_nxt;
      hold_dis_r <= hold_dis_nxt;
      ot_r <= ot_nxt;
      pin_oe_n_r <= pin_oe_n_nxt;
      deb_r <= deb_nxt;
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
      hyst_r <= hyst_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end
  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign dac_code = out_r;
  assign global_fault_pin_n_o = 1'b0;
  assign global_fault_pin_n_oe_n = pin_oe_n_r;
endmodule : dcac_dac_alarm

// ---- logic/dcac_pkg.sv ----
// Constants, register map and carrier types for the DAC update, clear and alarm block.
// Assumes a serial protocol engine outside that issues one-cycle register requests.
package dcac_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_DAC = 12;
  localparam int DAC_W = 12;
  localparam int NUM_IN = 4;
  localparam int NUM_TEMP = 3;
  localparam int NUM_MON = NUM_IN + NUM_TEMP;
  localparam int RES_W = 12;
  localparam int HYST_W = 7;
  localparam int CNT_W = 9;
  localparam int STAT_W = NUM_IN + 2 * NUM_TEMP + 1;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_HYST_BASE = 8'h18;
  localparam logic [7:0] ADDR_HI_BASE = 8'h20;
  localparam logic [7:0] ADDR_LO_BASE = 8'h28;
  localparam logic [7:0] ADDR_DEBOUNCE = 8'h4B;
  localparam logic [7:0] ADDR_CFG0 = 8'h4C;
  localparam logic [7:0] ADDR_ALM_CTRL = 8'h4D;
  localparam logic [7:0] ADDR_STATUS = 8'h4E;
  localparam logic [7:0] ADDR_SW_CLR = 8'h55;
  localparam logic [7:0] ADDR_PIN_SEL_A = 8'h56;
  localparam logic [7:0] ADDR_PIN_SEL_B = 8'h57;
  localparam logic [7:0] ADDR_LOAD_CFG = 8'h58;
  localparam logic [7:0] ADDR_AUTO_SRC = 8'h59;
  localparam logic [7:0] ADDR_AUTO_EN = 8'h5A;
  localparam logic [7:0] ADDR_DAC_BASE = 8'h60;
  localparam logic [7:0] ADDR_CODE_BASE = 8'h70;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG0_LOAD_BIT = 0;
  localparam int CFG0_SWRST_BIT = 1;
  localparam int CFG0_GFLAG_BIT = 15;
  localparam int ALM_HOLD_DIS_BIT = 15;
  localparam int DEB_IN_LSB = 0;
  localparam int DEB_TEMP_LSB = 4;
  localparam int STAT_UPPER_LSB = NUM_IN;
  localparam int STAT_LOWER_LSB = NUM_IN + NUM_TEMP;
  localparam int STAT_OVERTEMP_BIT = NUM_IN + 2 * NUM_TEMP;
  localparam int TEMP_HYST_W = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] DEBOUNCE_RST = 16'h0023;
  localparam logic [11:0] HI_RST = 12'hFFF;
  localparam logic [11:0] LO_RST = 12'h000;
  localparam logic [6:0] HYST_RST = 7'h00;
  localparam logic [10:0] UNMASK_RST = 11'h7FF;

  // ----------------------------------------------------------------
  // Die temperature limit
  // ----------------------------------------------------------------
  localparam int OVERTEMP_C = 150;
  localparam int OVERTEMP_HYST_C = 8;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dcac_req_t;

  typedef struct packed {
    logic [NUM_MON-1:0] valid;
    logic [NUM_MON-1:0][RES_W-1:0] result;
  } dcac_mon_t;

  typedef logic [NUM_DAC-1:0][DAC_W-1:0] dcac_dac_arr_t;

  // Consecutive-violation count from the input field code
  function automatic logic [CNT_W-1:0] dcac_need_in(input logic [2:0] code);
    logic [CNT_W-1:0] n;
    n = 9'h001;
    if (code != 3'h0) begin
      n = 9'h001 << ({1'b0, code} + 4'h1);
    end
    return n;
  endfunction : dcac_need_in

  // Consecutive-violation count from the temperature field code
  function automatic logic [CNT_W-1:0] dcac_need_temp(input logic [1:0] code);
    logic [CNT_W-1:0] n;
    case (code)
      2'h0: n = 9'h001;
      2'h1: n = 9'h002;
      default: n = 9'h008;
    endcase
    return n;
  endfunction : dcac_need_temp

endpackage : dcac_pkg

// ---- logic/dcac_limit_det.sv ----
// One monitored quantity: limit compare with debounce count and hysteresis.
// Assumes sample_valid is a one-cycle strobe from logic on the same clock.
`timescale 1ns/1ns
module dcac_limit_det
  import dcac_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Sample
  input wire logic sample_valid,
  input wire logic [RES_W-1:0] sample,
  // Settings
  input wire logic [RES_W-1:0] limit_hi,
  input wire logic [RES_W-1:0] limit_lo,
  input wire logic [HYST_W-1:0] hyst,
  input wire logic [CNT_W-1:0] need_count,
  // Alarm conditions
  output logic hi_alarm,
  output logic lo_alarm
);

  logic [CNT_W-1:0] hi_cnt_r, hi_cnt_nxt, lo_cnt_r, lo_cnt_nxt;
  logic hi_act_r, hi_act_nxt, lo_act_r, lo_act_nxt;
  logic [RES_W:0] up_back, lo_back;

  always_comb begin
    hi_cnt_nxt = hi_cnt_r;
    lo_cnt_nxt = lo_cnt_r;
    hi_act_nxt = hi_act_r;
    lo_act_nxt = lo_act_r;
    up_back = {1'b0, sample} + {6'h00, hyst};
    lo_back = {1'b0, sample} - {6'h00, hyst};
    if (sample_valid) begin
      if (sample > limit_hi) begin
        if (hi_cnt_r < need_count) begin
          hi_cnt_nxt = hi_cnt_r + 9'h001;
        end
        if (hi_cnt_nxt >= need_count) begin
          hi_act_nxt = 1'b1;
        end
      end else begin
        hi_cnt_nxt = '0;
        if (up_back <= {1'b0, limit_hi}) begin
          hi_act_nxt = 1'b0;
        end
      end
      if (sample < limit_lo) begin
        if (lo_cnt_r < need_count) begin
          lo_cnt_nxt = lo_cnt_r + 9'h001;
        end
        if (lo_cnt_nxt >= need_count) begin
          lo_act_nxt = 1'b1;
        end
      end else begin
        lo_cnt_nxt = '0;
        if (!lo_back[RES_W] && lo_back >= {1'b0, limit_lo}) begin
          lo_act_nxt = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt_r <= '0;
      lo_cnt_r <= '0;
      hi_act_r <= 1'b0;
      lo_act_r <= 1'b0;
    end else begin
      hi_cnt_r <= hi_cnt_nxt;
      lo_cnt_r <= lo_cnt_nxt;
      hi_act_r <= hi_act_nxt;
      lo_act_r <= lo_act_nxt;
    end
  end

  assign hi_alarm = hi_act_r;
  assign lo_alarm = lo_act_r;

endmodule : dcac_limit_det

// ---- sim/dcac_props.sv ----
// Port assertions for the DAC update, clear and alarm block.
// Bound to dcac_dac_alarm; sees its ports only.
`timescale 1ns/1ns
module dcac_props
  import dcac_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register bus
  input wire dcac_req_t reg_req,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  // Monitors and fault pin
  input wire dcac_mon_t mon_in,
  input wire logic die_temp_valid,
  input wire logic global_fault_pin_n_o,
  input wire logic global_fault_pin_n_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic cause;
  logic quiet;
  assign cause = (|mon_in.valid) || die_temp_valid || reg_req.wr;
  assign quiet = !cause && !reg_req.rd;
  read_answer_a: assert property (reg_req.rd |=> reg_rvalid)
    else $error("read not answered");
  answer_cause_a: assert property (reg_rvalid |-> $past(reg_req.rd))
    else $error("answer without read");
  idle_rdata_a: assert property (!reg_rvalid |-> reg_rdata == 16'h0000)
    else $error("read data outside answer");
  unmapped_read_a: assert property (reg_req.rd && reg_req.addr == 8'h00 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  status_width_a: assert property (reg_req.rd && reg_req.addr == ADDR_STATUS
    |=> reg_rdata[15:11] == 5'h00)
    else $error("status upper bits set");
  pin_data_a: assert property (global_fault_pin_n_o == 1'b0)
    else $error("fault pin data high");
  quiet_pin_a: assert property (quiet [*3] |=> $stable(global_fault_pin_n_oe_n))
    else $error("fault pin moved without cause");
  pin_cause_a: assert property ($fell(global_fault_pin_n_oe_n)
    |-> $past(cause) || $past(cause, 2) || $past(cause, 3))
    else $error("fault pin fell without event");
  cover property (!global_fault_pin_n_oe_n);
  cover property (reg_req.rd && reg_req.addr == ADDR_STATUS ##1 reg_rdata != 16'h0000);
  cover property (reg_req.wr && reg_req.addr == ADDR_SW_CLR);
endmodule : dcac_props

bind dcac_dac_alarm dcac_props i_dcac_props (.ref_clk, .rst_n, .reg_req, .reg_rdata,
  .reg_rvalid, .mon_in, .die_temp_valid, .global_fault_pin_n_o, .global_fault_pin_n_oe_n);

// ---- sim/dcac_host.sv ----
// Host model: register requests, and fault pin service.
// Requests change at the falling edge and are taken at the rising one.
`timescale 1ns/1ns
module dcac_host
  import dcac_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Register bus
  output dcac_req_t reg_req,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  // Fault pin level
  input wire logic fault_n
);
  initial reg_req = '0;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    reg_req.wr = 1'b1;
    reg_req.addr = a;
    reg_req.wdata = d;
    @(negedge ref_clk);
    reg_req.wr = 1'b0;
    reg_req.wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge ref_clk);
    reg_req.rd = 1'b1;
    reg_req.addr = a;
    @(negedge ref_clk);
    reg_req.rd = 1'b0;
    d = reg_rvalid ? reg_rdata : 16'hDEAD;
  endtask : rd
  task automatic serve_fault(output logic [15:0] s);
    s = 16'h0000;
    if (!fault_n) rd(ADDR_STATUS, s);
  endtask : serve_fault
endmodule : dcac_host

// ---- sim/dcac_dac_alarm_bench.sv ----
// Bench for the DAC update, clear and alarm block.
// Drives inputs on the falling edge; host model issues requests.
`timescale 1ns/1ns
module dcac_dac_alarm_bench
  import dcac_pkg::*;
;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } dcac_row_t;
  localparam int L = 4;
  localparam dcac_row_t ROWS [8] = '{'{1'b0, ADDR_HI_BASE, 16'h0000, 16'h0FFF},
    '{1'b0, ADDR_LO_BASE, 16'h0000, 16'h0000}, '{1'b0, ADDR_DEBOUNCE, 16'h0000, 16'h0023},
    '{1'b0, ADDR_ALM_CTRL, 16'h0000, 16'h07FF}, '{1'b0, ADDR_LOAD_CFG, 16'h0000, 16'h0000},
    '{1'b1, ADDR_PIN_SEL_B, 16'hFFFF, 16'h0FFF}, '{1'b1, ADDR_STATUS, 16'hFFFF, 16'h0000},
    '{1'b1, 8'h00, 16'hFFFF, 16'h0000}};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hw_a_n = 1'b1;
  logic hw_b_n = 1'b1;
  int mk = 0;
  logic die_v = 1'b0;
  logic [11:0] die_t = 12'h000;
  dcac_mon_t mon = '0;
  dcac_req_t req;
  logic [15:0] rdata;
  logic [15:0] v;
  logic rvalid;
  logic oe_n;
  logic pin_o;
  dcac_dac_arr_t dac;
  wire fault_n = oe_n ? 1'b1 : pin_o;
  int miscompares = 0;
  int n_checks = 0;
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  dcac_dac_alarm #(.TEMP_LSB_PER_C(L)) i_dcac_dac_alarm (.ref_clk, .rst_n, .reg_req(req),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .mon_in(mon), .die_temp_valid(die_v),
    .die_temp(die_t), .hw_clear_pin_a_n(hw_a_n), .hw_clear_pin_b_n(hw_b_n), .dac_code(dac),
    .global_fault_pin_n_o(pin_o), .global_fault_pin_n_oe_n(oe_n));
  dcac_host i_dcac_host (.ref_clk, .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .fault_n);
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    i_dcac_host.rd(a, v);
    check(v, e);
  endtask : rdc
  task automatic smp(input logic [11:0] r, input bit die);
    @(negedge ref_clk);
    mon.valid[mk] = !die;
    mon.result[mk] = r;
    die_v = die;
    die_t = r;
    @(negedge ref_clk);
    mon.valid = '0;
    die_v = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask : smp
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    foreach (ROWS[i]) begin
      if (ROWS[i].w) i_dcac_host.wr(ROWS[i].a, ROWS[i].d);
      rdc(ROWS[i].a, ROWS[i].e);
    end
    i_dcac_host.wr(ADDR_DAC_BASE, 16'h0123);
    check(16'(dac[0]), 16'h0123);
    i_dcac_host.wr(ADDR_LOAD_CFG, 16'h0002);
    i_dcac_host.wr(8'h61, 16'h0456);
    rdc(8'h61, 16'h0000);
    i_dcac_host.wr(ADDR_CFG0, 16'h0001);
    check(16'(dac[1]), 16'h0456);
    i_dcac_host.wr(8'h61, 16'h0789);
    i_dcac_host.wr(ADDR_CFG0, 16'h0001);
    check(16'(dac[1]), 16'h0456);
    i_dcac_host.wr(ADDR_CODE_BASE, 16'h0ABC);
    i_dcac_host.wr(ADDR_SW_CLR, 16'h0001);
    repeat (2) @(negedge ref_clk);
    check(16'(dac[0]), 16'h0ABC);
    i_dcac_host.wr(ADDR_SW_CLR, 16'h0000);
    repeat (2) @(negedge ref_clk);
    check(16'(dac[0]), 16'h0123);
    i_dcac_host.wr(ADDR_CODE_BASE + 8'h01, 16'h0321);
    i_dcac_host.wr(ADDR_PIN_SEL_A, 16'h0002);
    hw_a_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    check(16'(dac[1]), 16'h0321);
    hw_b_n = 1'b0;
    hw_a_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    check(16'(dac[0]), 16'h0ABC);
    hw_b_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    check(16'(dac[1]), 16'h0789);
    i_dcac_host.wr(ADDR_DEBOUNCE, 16'h0000);
    i_dcac_host.wr(ADDR_HI_BASE, 16'h0100);
    smp(12'h200, 1'b0);
    check(16'(fault_n), 16'h0000);
    i_dcac_host.serve_fault(v);
    check(v, 16'h0001);
    smp(12'h050, 1'b0);
    check(16'(fault_n), 16'h0000);
    rdc(ADDR_STATUS, 16'h0001);
    rdc(ADDR_STATUS, 16'h0000);
    check(16'(fault_n), 16'h0001);
    i_dcac_host.wr(ADDR_DEBOUNCE, 16'h0001);
    repeat (3) smp(12'h200, 1'b0);
    check(16'(fault_n), 16'h0001);
    smp(12'h200, 1'b0);
    check(16'(fault_n), 16'h0000);
    i_dcac_host.wr(ADDR_ALM_CTRL, 16'h8000);
    repeat (2) @(negedge ref_clk);
    check(16'(fault_n), 16'h0001);
    i_dcac_host.rd(ADDR_CFG0, v);
    check(16'(v[15]), 16'h0001);
    smp(12'h050, 1'b0);
    i_dcac_host.rd(ADDR_CFG0, v);
    check(16'(v[15]), 16'h0000);
    i_dcac_host.wr(ADDR_HI_BASE + 8'h01, 16'h0000);
    i_dcac_host.wr(ADDR_LO_BASE + 8'h01, 16'h0010);
    smp(12'(150 * L), 1'b1);
    rdc(ADDR_STATUS, 16'h0002);
    smp(12'(150 * L + 1), 1'b1);
    rdc(ADDR_STATUS, 16'h0402);
    mk = 4;
    i_dcac_host.wr(ADDR_HI_BASE + 8'h04, 16'h0100);
    i_dcac_host.wr(ADDR_HYST_BASE + 8'h04, 16'h0010);
    smp(12'h200, 1'b0);
    rdc(ADDR_STATUS, 16'h0412);
    smp(12'h0F8, 1'b0);
    rdc(ADDR_STATUS, 16'h0412);
    smp(12'h0F0, 1'b0);
    rdc(ADDR_STATUS, 16'h0402);
    i_dcac_host.wr(ADDR_CODE_BASE + 8'h02, 16'h0111);
    i_dcac_host.wr(ADDR_AUTO_SRC, 16'h0002);
    i_dcac_host.wr(ADDR_AUTO_EN, 16'h0004);
    repeat (2) @(negedge ref_clk);
    check(16'(dac[2]), 16'h0111);
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    rdc(ADDR_STATUS, 16'h0000);
    give_verdict();
  end
endmodule : dcac_dac_alarm_bench
